// file: core/adcspi_defs.svh
// Purpose: shared constants of the converter serial control block
// Assumes: included by bare name from the crc, device and host core files
// Notes:   offsets, field positions, reset values and timing counts
`ifndef ADCSPI_DEFS_SVH
`define ADCSPI_DEFS_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define ADC_OP_NOP            8'h00
`define ADC_OP_READ           8'h10
`define ADC_OP_WRITE          8'h08
`define ADC_OP_SET            8'h18
`define ADC_OP_CLEAR          8'h20

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADC_REG_STATUS        8'h00
`define ADC_REG_GENERAL       8'h01
`define ADC_REG_SEQ_CFG       8'h10
`define ADC_REG_CHAN_SEL      8'h11
`define ADC_REG_SEQ_ENABLE    8'h12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADC_ST_RESET_EVENT    0
`define ADC_ST_CRC_ERR        1
`define ADC_ST_SEQ_ACTIVE     6
`define ADC_ST_FIXED_ONE      7
`define ADC_GEN_SOFT_RESET    0
`define ADC_GEN_CRC_EN        6
`define ADC_CHANNEL_SELECT_MODE_LSB      0
`define ADC_SEQ_RUN           4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADC_GENERAL_RST       8'h00
`define ADC_SEQ_CFG_RST       8'h00
`define ADC_CHAN_SEL_RST      8'h00
`define ADC_SEQ_ENABLE_RST    8'h00

// ----------------------------------------------------------------
// frame layout and crc
// ----------------------------------------------------------------
`define ADC_FRAME_BITS        6'd24
`define ADC_FRAME_CRC_BITS    6'd32
`define ADC_OTF_BITS          6'd5
`define ADC_CRC_POLY          8'h07
`define ADC_CRC_INIT          8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADC_MCLK_PERIOD_NS    25
`define ADC_SCLK_HALF_NS      250
`define ADC_SCLK_HALF_CYCLES  ((`ADC_SCLK_HALF_NS + `ADC_MCLK_PERIOD_NS - 1) / `ADC_MCLK_PERIOD_NS)

`endif

// file: core/adcspi_pkg.sv
// Purpose: types shared by both ends of the serial link
// Assumes: nothing beyond the defs header
// Notes:   mode codes follow the 2-bit mode field
package adcspi_pkg;
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'b00,
		MODE_SEQ    = 2'b01,
		MODE_OTF    = 2'b10,
		MODE_RSVD   = 2'b11
	} chan_mode_e;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LEAD = 3'b001,
		H_HIGH = 3'b010,
		H_LOW  = 3'b011,
		H_TAIL = 3'b100,
		H_GAP  = 3'b101
	} host_state_e;
endpackage

// file: core/adcspi_if.sv
// Purpose: four-wire serial link between host and converter control
// Assumes: host makes clock and chip select, idle clock low
// Notes:   no tristate, the converter output is always driven
`timescale 1ns/10ps
`default_nettype none
interface adcspi_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;

	modport device (input cs_n, input sclk, input sdi, output sdo);
	modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface
`default_nettype wire

// file: core/adcspi_crc8.sv
// Purpose: combinational crc byte over a word, msb first
// Assumes: polynomial and seed from the defs header
// Notes:   used by both ends for 24-bit and 8-bit inputs
`timescale 1ns/10ps
`default_nettype none
`include "adcspi_defs.svh"
module adcspi_crc8 #(
	parameter int WIDTH = 24
) (
	input  wire logic [WIDTH-1:0] data_in,
	output logic      [7:0]       crc_out
);
	// bitwise lfsr, unrolled by synthesis
	always_comb begin
		logic fb;
		fb = 1'b0;
		crc_out = `ADC_CRC_INIT;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			fb = crc_out[7] ^ data_in[i];
			crc_out = {crc_out[6:0], 1'b0};
			if (fb) begin
				crc_out = crc_out ^ `ADC_CRC_POLY;
			end
		end
	end
endmodule
`default_nettype wire

// file: core/adcspi_device.sv
// Purpose: converter-side serial command decode and channel control
// Assumes: link pins come from another domain and are synchronised
// Notes:   serial mode 00 only; analog core and result data not here
//
// Operation
// (RL1) host writes: opcode 08h, address, data
// (RL2) write decoded at chip-select rise, register loaded
// (RL3) host read frame: opcode 10h, address, dummy
// (RL4) read data leads the next frame's output
// (RL5) command in read-return frame processed normally
// (RL6) crc enabled: crc byte follows read data
// (RL7) mode field: 00 manual, 10 fly, 01 sequencer
// (RL8) chip-select rise starts each conversion
// (RL9) manual channel mode after power-up
// (RL10) reset sets flag; soft reset bit resets all
// (RL11) manual change sampled two conversions later
// (RL12) host changes manual channel by full write
// (RL13) fly mode: first five bits pick channel
// (RL14) fly code 1_0xxx selects input, rest reserved
// (RL15) sequencer steps ascending through enabled channels
// (RL16) run bit starts, clearing stops the sequencer
// (RL17) sequencer wraps from highest to lowest enabled
// (RL18) opcodes 00h nop, 18h set, 20h clear
// (RL19) crc enabled: 32-bit frames, payload crc checked
// (RL20) reserved fly code leaves mux unchanged
// (RL21) host holds select low whole frame
`timescale 1ns/10ps
`default_nettype none
`include "adcspi_defs.svh"
module adcspi_device
	import adcspi_pkg::*;
(
	input  wire logic   MCLK_IN,
	input  wire logic   RST_IN,
	adcspi_if.device    link,
	output logic [2:0]  MUX_CHANNEL_OUT,
	output logic        CONV_START_OUT,
	output logic [2:0]  CONV_CHANNEL_OUT,
	output logic [1:0]  MODE_OUT,
	output logic        SEQ_ACTIVE_OUT,
	output logic        CRC_ERR_OUT,
	output logic        RESET_EVENT_OUT
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// write replaces the old value; set-bits and clear-bits merge onto it
	function automatic logic [7:0] merge(input logic [7:0] op, input logic [7:0] old, input logic [7:0] d);
		case (op)
			`ADC_OP_WRITE: merge = d;
			`ADC_OP_SET:   merge = old | d;   // [RL18]
			`ADC_OP_CLEAR: merge = old & ~d;  // [RL18]
			default:       merge = old;
		endcase
	endfunction

	// next enabled channel above cur, wrapping round
	function automatic logic [2:0] next_enabled(input logic [2:0] cur, input logic [7:0] mask);
		logic       found;
		logic [2:0] idx;
		found = 1'b0;
		next_enabled = cur;
		for (int k = 1; k <= 8; k++) begin
			idx = 3'(cur + 3'(k));
			if (!found && mask[idx]) begin
				found = 1'b1;
				next_enabled = idx;  // [RL15] [RL17]
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cs_sync_r;
	logic [2:0] sclk_sync_r;
	logic [1:0] sdi_sync_r;
	logic       rst;
	logic       soft_rst_r;

	assign rst = RST_IN | soft_rst_r;

	// stage 0 feeds only stage 1; edges come from stages 1 and 2
	always_ff @(posedge MCLK_IN) begin
		if (rst) begin
			cs_sync_r   <= 3'h7;
			sclk_sync_r <= 3'h0;
			sdi_sync_r  <= 2'h0;
		end else begin
			cs_sync_r   <= {cs_sync_r[1:0], link.cs_n};
			sclk_sync_r <= {sclk_sync_r[1:0], link.sclk};
			sdi_sync_r  <= {sdi_sync_r[0], link.sdi};
		end
	end

	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	assign cs_low    = ~cs_sync_r[1];
	assign cs_fall   = ~cs_sync_r[1] & cs_sync_r[2];
	assign cs_rise   = cs_sync_r[1] & ~cs_sync_r[2];
	assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
	assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];

	// ----------------------------------------------------------------
	// registers and decode inputs
	// ----------------------------------------------------------------
	logic [31:0] rx_r, rx_nxt;
	logic [31:0] tx_r, tx_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic        otf_valid_r, otf_valid_nxt;
	logic [2:0]  otf_ch_r, otf_ch_nxt;
	logic        reset_event_r, reset_event_nxt;
	logic        crc_err_r, crc_err_nxt;
	logic [7:0]  general_r, general_nxt;
	logic [7:0]  seq_cfg_r, seq_cfg_nxt;
	logic [7:0]  chan_sel_r, chan_sel_nxt;
	logic [7:0]  seq_en_r, seq_en_nxt;
	logic [2:0]  mux_r, mux_nxt;
	logic        conv_start_r, conv_start_nxt;
	logic [2:0]  conv_ch_r, conv_ch_nxt;
	logic        soft_rst_nxt;

	logic        crc_en;
	logic [23:0] payload;
	logic [7:0]  op;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [7:0]  crc_in;
	logic [7:0]  crc_rd;
	logic        cmd_ok;
	logic        wr_op;
	logic        seq_active;
	chan_mode_e  mode;

	assign crc_en     = general_r[`ADC_GEN_CRC_EN];
	assign payload    = crc_en ? rx_r[31:8] : rx_r[23:0];  // [RL19]
	assign op         = payload[23:16];
	assign addr       = payload[15:8];
	assign wdata      = payload[7:0];
	assign wr_op      = (op == `ADC_OP_WRITE) || (op == `ADC_OP_SET) || (op == `ADC_OP_CLEAR);
	assign mode       = chan_mode_e'(seq_cfg_r[`ADC_CHANNEL_SELECT_MODE_LSB +: 2]);  // [RL7]
	assign seq_active = (mode == MODE_SEQ) && seq_cfg_r[`ADC_SEQ_RUN];

	// short frames and crc mismatches carry no command
	assign cmd_ok = crc_en ? ((cnt_r == `ADC_FRAME_CRC_BITS) && (crc_in == rx_r[7:0]))  // [RL19]
	                       : (cnt_r == `ADC_FRAME_BITS);

	// register read view; unmapped addresses read zero
	always_comb begin
		case (addr)
			`ADC_REG_STATUS:     rdata = {1'b1, seq_active, 4'h0, crc_err_r, reset_event_r};
			`ADC_REG_GENERAL:    rdata = general_r;
			`ADC_REG_SEQ_CFG:    rdata = seq_cfg_r;
			`ADC_REG_CHAN_SEL:   rdata = chan_sel_r;
			`ADC_REG_SEQ_ENABLE: rdata = seq_en_r;
			default:             rdata = 8'h00;
		endcase
	end

	adcspi_crc8 #(.WIDTH(24)) crc_payload (
		.data_in (rx_r[31:8]),
		.crc_out (crc_in)
	);

	// output crc covers only the register byte
	adcspi_crc8 #(.WIDTH(8)) crc_read (
		.data_in (rdata),
		.crc_out (crc_rd)
	);

	// ----------------------------------------------------------------
	// frame shifting, command decode and channel control
	// ----------------------------------------------------------------
	always_comb begin
		rx_nxt          = rx_r;
		tx_nxt          = tx_r;
		cnt_nxt         = cnt_r;
		otf_valid_nxt   = otf_valid_r;
		otf_ch_nxt      = otf_ch_r;
		reset_event_nxt = reset_event_r;
		crc_err_nxt     = crc_err_r;
		general_nxt     = general_r;
		seq_cfg_nxt     = seq_cfg_r;
		chan_sel_nxt    = chan_sel_r;
		seq_en_nxt      = seq_en_r;
		mux_nxt         = mux_r;
		conv_start_nxt  = 1'b0;
		conv_ch_nxt     = conv_ch_r;
		soft_rst_nxt    = 1'b0;

		if (cs_fall) begin
			rx_nxt        = 32'h0000_0000;
			cnt_nxt       = 6'h00;
			otf_valid_nxt = 1'b0;
		end else if (cs_low && sclk_rise) begin
			rx_nxt = {rx_r[30:0], sdi_sync_r[1]};
			if (cnt_r != 6'h3F) begin
				cnt_nxt = 6'(cnt_r + 6'h01);
			end
			// channel taken as soon as five bits are in [RL13]
			if ((cnt_r == `ADC_OTF_BITS - 6'h01) && rx_nxt[4] && !rx_nxt[3]) begin  // [RL14] [RL20]
				otf_valid_nxt = 1'b1;
				otf_ch_nxt    = rx_nxt[2:0];
			end
		end else if (cs_low && sclk_fall && (cnt_r != 6'h00)) begin
			tx_nxt = {tx_r[30:0], 1'b0};
		end

		if (cs_rise) begin
			// every rise starts a conversion, on the current mux unless fly mode has a valid code [RL8] [RL11]
			conv_start_nxt = 1'b1;
			conv_ch_nxt    = mux_r;
			tx_nxt         = 32'h0000_0000;
			if (crc_en && (cnt_r == `ADC_FRAME_CRC_BITS) && (crc_in != rx_r[7:0])) begin
				crc_err_nxt = 1'b1;  // [RL19]
			end
			if (cmd_ok) begin  // [RL5]
				if (op == `ADC_OP_READ) begin
					tx_nxt = {rdata, crc_en ? crc_rd : 8'h00, 16'h0000};  // [RL4] [RL6]
				end else if (wr_op) begin  // [RL2]
					case (addr)
						`ADC_REG_STATUS: begin
							// write one to clear; a bad-crc frame never gets here, so a set cannot clash
							if (wdata[`ADC_ST_RESET_EVENT]) begin
								reset_event_nxt = 1'b0;
							end
							if (wdata[`ADC_ST_CRC_ERR]) begin
								crc_err_nxt = 1'b0;
							end
						end
						`ADC_REG_GENERAL: begin
							general_nxt  = merge(op, general_r, wdata);
							soft_rst_nxt = general_nxt[`ADC_GEN_SOFT_RESET];  // [RL10]
							general_nxt[`ADC_GEN_SOFT_RESET] = 1'b0;
						end
						`ADC_REG_SEQ_CFG:    seq_cfg_nxt  = merge(op, seq_cfg_r, wdata);
						`ADC_REG_CHAN_SEL:   chan_sel_nxt = merge(op, chan_sel_r, wdata);
						`ADC_REG_SEQ_ENABLE: seq_en_nxt   = merge(op, seq_en_r, wdata);
						default: ;
					endcase
				end
			end
			// mux for the next conversion
			case (mode)
				MODE_OTF: begin
					if (otf_valid_r) begin
						conv_ch_nxt = otf_ch_r;  // [RL13]
						mux_nxt     = otf_ch_r;
					end
				end
				MODE_SEQ: begin
					if (seq_cfg_r[`ADC_SEQ_RUN]) begin
						mux_nxt = next_enabled(mux_r, seq_en_r);  // [RL15] [RL16]
					end else if (seq_cfg_nxt[`ADC_SEQ_RUN]) begin
						mux_nxt = next_enabled(3'h7, seq_en_nxt);  // [RL16]
					end
				end
				// new manual channel lands after this conversion [RL11]
				default: mux_nxt = chan_sel_nxt[2:0];
			endcase
		end
	end

	// reset puts the block in manual mode and raises the flag [RL9] [RL10]
	always_ff @(posedge MCLK_IN) begin
		if (rst) begin
			rx_r          <= 32'h0000_0000;
			tx_r          <= 32'h0000_0000;
			cnt_r         <= 6'h00;
			otf_valid_r   <= 1'b0;
			otf_ch_r      <= 3'h0;
			reset_event_r <= 1'b1;
			crc_err_r     <= 1'b0;
			general_r     <= `ADC_GENERAL_RST;
			seq_cfg_r     <= `ADC_SEQ_CFG_RST;
			chan_sel_r    <= `ADC_CHAN_SEL_RST;
			seq_en_r      <= `ADC_SEQ_ENABLE_RST;
			mux_r         <= 3'h0;
			conv_start_r  <= 1'b0;
			conv_ch_r     <= 3'h0;
		end else begin
			rx_r          <= rx_nxt;
			tx_r          <= tx_nxt;
			cnt_r         <= cnt_nxt;
			otf_valid_r   <= otf_valid_nxt;
			otf_ch_r      <= otf_ch_nxt;
			reset_event_r <= reset_event_nxt;
			crc_err_r     <= crc_err_nxt;
			general_r     <= general_nxt;
			seq_cfg_r     <= seq_cfg_nxt;
			chan_sel_r    <= chan_sel_nxt;
			seq_en_r      <= seq_en_nxt;
			mux_r         <= mux_nxt;
			conv_start_r  <= conv_start_nxt;
			conv_ch_r     <= conv_ch_nxt;
		end
	end

	// soft reset pulse only cleared by the pin reset, else it would kill itself early
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= soft_rst_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link.sdo         = tx_r[31];
	assign MUX_CHANNEL_OUT  = mux_r;
	assign CONV_START_OUT   = conv_start_r;
	assign CONV_CHANNEL_OUT = conv_ch_r;
	assign MODE_OUT         = seq_cfg_r[`ADC_CHANNEL_SELECT_MODE_LSB +: 2];
	assign SEQ_ACTIVE_OUT   = seq_active;
	assign CRC_ERR_OUT      = crc_err_r;
	assign RESET_EVENT_OUT  = reset_event_r;
endmodule
`default_nettype wire

// file: core/adcspi_host.sv
// Purpose: host end that frames commands onto the serial link
// Assumes: serial mode 00, clock made here by a divider
// Notes:   user supplies 24-bit payloads; crc byte appended here
`timescale 1ns/10ps
`default_nettype none
`include "adcspi_defs.svh"
module adcspi_host
	import adcspi_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        RST_IN,
	adcspi_if.host           link,
	input  wire logic        CMD_VALID_IN,
	output logic             CMD_READY_OUT,
	input  wire logic [23:0] CMD_PAYLOAD_IN,
	input  wire logic        CRC_EN_IN,
	output logic             RESP_VALID_OUT,
	output logic [7:0]       RESP_DATA_OUT,
	output logic [7:0]       RESP_CRC_OUT,
	output logic             RESP_CRC_OK_OUT
);
	localparam logic [7:0] HALF = 8'(`ADC_SCLK_HALF_CYCLES);

	// ----------------------------------------------------------------
	// return data synchroniser
	// ----------------------------------------------------------------
	logic [1:0] sdo_sync_r;

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			sdo_sync_r <= 2'h0;
		end else begin
			sdo_sync_r <= {sdo_sync_r[0], link.sdo};
		end
	end

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	host_state_e state_r, state_nxt;
	logic [7:0]  timer_r, timer_nxt;
	logic [5:0]  bits_r, bits_nxt;
	logic [5:0]  nbits_r, nbits_nxt;
	logic [31:0] tx_r, tx_nxt;
	logic [31:0] rx_r, rx_nxt;
	logic        cs_n_r, cs_n_nxt;
	logic        sclk_r, sclk_nxt;
	logic        resp_valid_r, resp_valid_nxt;
	logic [7:0]  resp_data_r, resp_data_nxt;
	logic [7:0]  resp_crc_r, resp_crc_nxt;
	logic [7:0]  cmd_crc;
	logic [7:0]  rx_crc;
	logic [31:0] rx_al;

	adcspi_crc8 #(.WIDTH(24)) crc_cmd (
		.data_in (CMD_PAYLOAD_IN),
		.crc_out (cmd_crc)
	);

	// held data byte checked against the held crc byte, stable until the next frame ends
	adcspi_crc8 #(.WIDTH(8)) crc_resp (
		.data_in (resp_data_r),
		.crc_out (rx_crc)
	);

	assign rx_al = (nbits_r == `ADC_FRAME_CRC_BITS) ? rx_r : {rx_r[23:0], 8'h00};

	// clock idles low; data changes on falling edge, sampled on rising
	always_comb begin
		state_nxt      = state_r;
		timer_nxt      = timer_r;
		bits_nxt       = bits_r;
		nbits_nxt      = nbits_r;
		tx_nxt         = tx_r;
		rx_nxt         = rx_r;
		cs_n_nxt       = cs_n_r;
		sclk_nxt       = sclk_r;
		resp_valid_nxt = 1'b0;
		resp_data_nxt  = resp_data_r;
		resp_crc_nxt   = resp_crc_r;
		if (timer_r != 8'h00) begin
			timer_nxt = 8'(timer_r - 8'h01);
		end
		case (state_r)
			H_IDLE: begin
				if (CMD_VALID_IN) begin
					// opcode, address, data, then crc when enabled [RL1] [RL3] [RL12] [RL19]
					tx_nxt    = {CMD_PAYLOAD_IN, CRC_EN_IN ? cmd_crc : 8'h00};
					nbits_nxt = CRC_EN_IN ? `ADC_FRAME_CRC_BITS : `ADC_FRAME_BITS;
					bits_nxt  = 6'h00;
					rx_nxt    = 32'h0000_0000;
					cs_n_nxt  = 1'b0;  // [RL21]
					timer_nxt = 8'(HALF - 8'h01);
					state_nxt = H_LEAD;
				end
			end
			H_LEAD, H_LOW: begin
				if (timer_r == 8'h00) begin
					sclk_nxt  = 1'b1;
					rx_nxt    = {rx_r[30:0], sdo_sync_r[1]};
					timer_nxt = 8'(HALF - 8'h01);
					state_nxt = H_HIGH;
				end
			end
			H_HIGH: begin
				if (timer_r == 8'h00) begin
					sclk_nxt  = 1'b0;
					bits_nxt  = 6'(bits_r + 6'h01);
					tx_nxt    = {tx_r[30:0], 1'b0};
					timer_nxt = 8'(HALF - 8'h01);
					state_nxt = (bits_nxt == nbits_r) ? H_TAIL : H_LOW;
				end
			end
			H_TAIL: begin
				if (timer_r == 8'h00) begin
					cs_n_nxt       = 1'b1;  // [RL21]
					resp_valid_nxt = 1'b1;
					resp_data_nxt  = rx_al[31:24];
					resp_crc_nxt   = rx_al[23:16];
					timer_nxt      = 8'(HALF - 8'h01);
					state_nxt      = H_GAP;
				end
			end
			H_GAP: begin
				if (timer_r == 8'h00) begin
					state_nxt = H_IDLE;
				end
			end
			default: state_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			state_r      <= H_IDLE;
			timer_r      <= 8'h00;
			bits_r       <= 6'h00;
			nbits_r      <= `ADC_FRAME_BITS;
			tx_r         <= 32'h0000_0000;
			rx_r         <= 32'h0000_0000;
			cs_n_r       <= 1'b1;
			sclk_r       <= 1'b0;
			resp_valid_r <= 1'b0;
			resp_data_r  <= 8'h00;
			resp_crc_r   <= 8'h00;
		end else begin
			state_r      <= state_nxt;
			timer_r      <= timer_nxt;
			bits_r       <= bits_nxt;
			nbits_r      <= nbits_nxt;
			tx_r         <= tx_nxt;
			rx_r         <= rx_nxt;
			cs_n_r       <= cs_n_nxt;
			sclk_r       <= sclk_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_data_r  <= resp_data_nxt;
			resp_crc_r   <= resp_crc_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link.cs_n       = cs_n_r;
	assign link.sclk       = sclk_r;
	assign link.sdi        = tx_r[31];
	assign CMD_READY_OUT   = (state_r == H_IDLE);
	assign RESP_VALID_OUT  = resp_valid_r;
	assign RESP_DATA_OUT   = resp_data_r;
	assign RESP_CRC_OUT    = resp_crc_r;
	assign RESP_CRC_OK_OUT = (resp_crc_r == rx_crc) || (nbits_r != `ADC_FRAME_CRC_BITS);
endmodule
`default_nettype wire

// file: verif/adcspi_assertions.sv
// Purpose: wire and control checks beside the serial link
// Assumes: one clock domain, sync reset active high
// Notes:   sdo is checked only for stability while the clock is high
`timescale 1ns/10ps
`default_nettype none
module adcspi_assertions (
	input wire logic       MCLK_IN,
	input wire logic       RST_IN,
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic       sdi,
	input wire logic       sdo,
	input wire logic       CONV_START_OUT,
	input wire logic [2:0] MUX_CHANNEL_OUT,
	input wire logic [1:0] MODE_OUT,
	input wire logic       SEQ_ACTIVE_OUT,
	input wire logic       RESET_EVENT_OUT
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);

	reset_values_a: assert property (disable iff (1'b0) RST_IN |=> MODE_OUT == 2'b00 && RESET_EVENT_OUT)
		else $error("reset values wrong");
	cs_rise_conv_a: assert property ($rose(cs_n) |-> ##[2:6] CONV_START_OUT)
		else $error("no conversion after select rise");
	conv_cause_a: assert property (CONV_START_OUT |-> cs_n && !$past(cs_n, 8))
		else $error("conversion without select rise");
	conv_pulse_a: assert property (CONV_START_OUT |=> !CONV_START_OUT)
		else $error("conversion start longer than a cycle");
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("serial clock moves outside frame");
	sdi_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdi))
		else $error("serial input changes while clock high");
	sdo_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdo))
		else $error("serial output changes while clock high");
	channel_select_mode_a: assert property (SEQ_ACTIVE_OUT |-> MODE_OUT == 2'b01)
		else $error("sequencer active outside its mode");
	mode_at_cs_a: assert property ($changed(MODE_OUT) |-> cs_n)
		else $error("mode changed inside a frame");
	mux_at_cs_a: assert property ($changed(MUX_CHANNEL_OUT) |-> cs_n)
		else $error("mux changed inside a frame");

	// main scenarios reached
	fly_conv_c: cover property (CONV_START_OUT && MODE_OUT == 2'b10);
	seq_conv_c: cover property (CONV_START_OUT && SEQ_ACTIVE_OUT);
	flag_clear_c: cover property ($fell(RESET_EVENT_OUT));
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: host and device joined, driven through the host user side
// Assumes: host frames 24 bits, 32 with crc on
// Notes:   device outputs checked 8 cycles after frame end
`timescale 1ns/10ps
`default_nettype none
`include "adcspi_defs.svh"
module tb_top
	import adcspi_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic        clk, rst, valid, crc_en, ready, resp_valid, resp_crc_ok;
	logic        conv_start, seq_act, crc_err, rst_evt;
	logic [23:0] payload;
	logic [7:0]  resp_data, resp_crc;
	logic [2:0]  mux, conv_ch;
	logic [1:0]  mode;
	int          n_errors, check_count;

	adcspi_if link_if ();
	adcspi_host i_adcspi_host (.MCLK_IN(clk), .RST_IN(rst), .link(link_if), .CMD_VALID_IN(valid),
		.CMD_READY_OUT(ready), .CMD_PAYLOAD_IN(payload), .CRC_EN_IN(crc_en), .RESP_VALID_OUT(resp_valid),
		.RESP_DATA_OUT(resp_data), .RESP_CRC_OUT(resp_crc), .RESP_CRC_OK_OUT(resp_crc_ok));
	adcspi_device i_adcspi_device (.MCLK_IN(clk), .RST_IN(rst), .link(link_if), .MUX_CHANNEL_OUT(mux),
		.CONV_START_OUT(conv_start), .CONV_CHANNEL_OUT(conv_ch), .MODE_OUT(mode), .SEQ_ACTIVE_OUT(seq_act),
		.CRC_ERR_OUT(crc_err), .RESET_EVENT_OUT(rst_evt));
	adcspi_assertions i_adcspi_assertions (.MCLK_IN(clk), .RST_IN(rst), .cs_n(link_if.cs_n),
		.sclk(link_if.sclk), .sdi(link_if.sdi), .sdo(link_if.sdo), .CONV_START_OUT(conv_start),
		.MUX_CHANNEL_OUT(mux), .MODE_OUT(mode), .SEQ_ACTIVE_OUT(seq_act), .RESET_EVENT_OUT(rst_evt));

	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one frame; bounded waits so a stuck handshake counts as a mismatch
	task send(input logic [23:0] p);
		int i;
		i = 0;
		while (ready !== 1'b1 && i < 100) begin
			@(posedge clk);
			i++;
		end
		if (i >= 100)
			chk(8'h01, 8'h00);
		valid <= 1'b1;
		payload <= p;
		@(posedge clk);
		valid <= 1'b0;
		i = 0;
		while (resp_valid !== 1'b1 && i < 1000) begin
			@(posedge clk);
			i++;
		end
		if (i >= 1000)
			chk(8'h01, 8'h00);
		repeat (8) @(posedge clk);
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int k = 7; k >= 0; k--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	task test_done;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 0;
		rst = 1;
		valid = 0;
		crc_en = 0;
		payload = 24'h000000;
		n_errors = 0;
		check_count = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk(mode, 8'h00);
		chk(rst_evt, 8'h01);
		send({`ADC_OP_READ, `ADC_REG_STATUS, 8'h00});
		send({`ADC_OP_WRITE, `ADC_REG_STATUS, 8'h01});
		chk(resp_data, 8'h81);
		chk(rst_evt, 8'h00);
		// manual change only shows one conversion later
		send({`ADC_OP_WRITE, `ADC_REG_CHAN_SEL, 8'h05});
		chk(conv_ch, 8'h00);
		send({`ADC_OP_NOP, 16'h0000});
		chk(conv_ch, 8'h05);
		send({`ADC_OP_SET, `ADC_REG_CHAN_SEL, 8'h06});
		send({`ADC_OP_CLEAR, `ADC_REG_CHAN_SEL, 8'h03});
		send({`ADC_OP_READ, `ADC_REG_CHAN_SEL, 8'h00});
		send({`ADC_OP_NOP, 16'h0000});
		chk(resp_data, 8'h04);
		send({`ADC_OP_WRITE, `ADC_REG_SEQ_CFG, 8'h02});
		chk(mode, 8'h02);
		for (int c = 0; c < 8; c++) begin
			send({2'b10, c[2:0], 19'h7FFFF});
			chk(conv_ch, c[7:0]);
		end
		send(24'hD7FFFF);
		chk(mux, 8'h07);
		// sequence over channels 2 and 6, wrap checked once
		send({`ADC_OP_WRITE, `ADC_REG_SEQ_ENABLE, 8'h44});
		// mode first, so the run write starts at the lowest enabled channel
		send({`ADC_OP_WRITE, `ADC_REG_SEQ_CFG, 8'h01});
		chk(seq_act, 8'h00);
		send({`ADC_OP_WRITE, `ADC_REG_SEQ_CFG, 8'h11});
		chk(mux, 8'h02);
		chk(seq_act, 8'h01);
		for (int k = 0; k < 3; k++) begin
			send({`ADC_OP_NOP, 16'h0000});
			chk(conv_ch, (k == 1) ? 8'h06 : 8'h02);
		end
		send({`ADC_OP_WRITE, `ADC_REG_SEQ_CFG, 8'h01});
		chk(seq_act, 8'h00);
		send({`ADC_OP_WRITE, `ADC_REG_GENERAL, 8'h40});
		crc_en <= 1'b1;
		send({`ADC_OP_READ, `ADC_REG_SEQ_ENABLE, 8'h00});
		send({`ADC_OP_NOP, 16'h0000});
		chk(resp_data, 8'h44);
		chk(resp_crc, crc8(8'h44));
		chk(resp_crc_ok, 8'h01);
		chk(crc_err, 8'h00);
		send({`ADC_OP_WRITE, `ADC_REG_GENERAL, 8'h01});
		chk(rst_evt, 8'h01);
		chk(mode, 8'h00);
		test_done();
	end

	// watchdog well beyond the roughly 15000 cycles of traffic
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
